//--- rtl/rsc_pkg.sv
// Constants and types shared by the reset strap loader
package rsc_pkg;

  // ****************************************
  // Pin map
  // ****************************************
  localparam int GPIO_N = 10;
  localparam int PROTO_PIN = 9;
  localparam int HOLD_PIN = 8;
  localparam int SEL_W = 10;
  localparam int RANK_W = 4;
  localparam int CLK_OUT_N = 8;
  localparam logic [GPIO_N-1:0] DEF_SEL_MASK = 10'h00f;
  localparam logic [GPIO_N-1:0] NO_ROLE_MASK = 10'h000;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [SEL_W-1:0] SEL_RST = 10'h000;
  localparam logic [CLK_OUT_N-1:0] CLK_OUT_RST = 8'h00;
  localparam logic [GPIO_N-1:0] GPIO_INPUT_RST = 10'h3ff;
  localparam logic [SEL_W-1:0] SEL_ZERO = 10'h000;

  // ****************************************
  // Start-up sequence, Gray coded
  // ****************************************
  typedef enum logic [2:0] {
    RSC_ST_IDLE = 3'h0,
    RSC_ST_LOAD = 3'h1,
    RSC_ST_REG = 3'h3,
    RSC_ST_CLK = 3'h2,
    RSC_ST_CAL = 3'h6,
    RSC_ST_LOCK = 3'h7,
    RSC_ST_RUN = 3'h5
  } rsc_seq_type;

  localparam int STEP_N = 4;
  localparam logic [STEP_N-1:0] STEP_NONE = 4'h0;
  localparam logic [STEP_N-1:0] STEP_REG = 4'h1;
  localparam logic [STEP_N-1:0] STEP_CLK = 4'h2;
  localparam logic [STEP_N-1:0] STEP_CAL = 4'h4;
  localparam logic [STEP_N-1:0] STEP_LOCK = 4'h8;

endpackage

//--- rtl/rsc_role_decode.sv
// Role decode: packs strap pins into select word, address bit and disable
`timescale 1ns/1ps
module rsc_role_decode
  import rsc_pkg::*;
(
  input wire logic [GPIO_N-1:0] pins,
  input wire logic [GPIO_N-1:0] addr_mask,
  input wire logic [GPIO_N-1:0] eep_mask,
  input wire logic [GPIO_N-1:0] sel_mask,
  output logic [SEL_W-1:0] sel_word,
  output logic addr_bit,
  output logic eep_dis
);

  logic [GPIO_N-1:0] sel_mask_eff;

  // R8 R9: default select pins
  assign sel_mask_eff = (sel_mask == NO_ROLE_MASK) ? DEF_SEL_MASK : sel_mask;

  // R7: any disable pin wins
  assign eep_dis = |(pins & eep_mask);

  // ****************************************
  // Index-ordered packing
  // ****************************************
  always_comb begin
    logic [RANK_W-1:0] rank;
    rank = '0;
    // R12: upper bits zero
    sel_word = SEL_ZERO;
    addr_bit = 1'b0;
    for (int i = 0; i < GPIO_N; i++) begin
      // R10: lowest index is LSB
      if (sel_mask_eff[i]) begin
        sel_word[rank] = pins[i];
        rank = rank + 4'h1;
      end
      // R5: highest index overrides
      if (addr_mask[i]) begin
        addr_bit = pins[i];
      end
    end
  end

endmodule

//--- rtl/rsc_strap_loader.sv
// Reset strap capture, initial configuration select and start-up sequence
// Notes on behaviour
// R1: Every pin level is captured at master reset rising edge; settings derive from it.
// R2: Captured pin 9 low selects SPI, high selects I2C on auxiliary port.
// R3: Board keeps pin 8 high throughout master reset.
// R4: Address-role pin sets slave address bit two in I2C only; none gives zero.
// R5: Several address-role pins: highest index pin is used.
// R6: High on an EEPROM-disable pin stops EEPROM search; none assigned means search.
// R7: Several EEPROM-disable pins are ORed together.
// R8: No select pins assigned: pins 3 down to 0 form the select value.
// R9: Undriven pulled-up default pins select stored configuration 15.
// R10: Select bits follow pin index order, lowest pin is LSB.
// R11: Device information block may pick other select pins.
// R12: Fewer than four select pins leave upper bits zero.
// R13: More than four select pins build a wider select word.
// R14: Select chooses stored configuration; no effect when none is stored.
// R15: Serial port writes replace every strap-derived setting afterwards.
// R16: Defaults: clock outputs disabled, all pins general-purpose inputs.
// R17: Sequence: load config, regulators, clocks, PLL calibration, PLL lock.
// R18: Pin roles come from device information block; unprogrammed keeps defaults.
// R19: Board should not give JTAG pins any strap role.
// R20: Stored configuration failing checksum is skipped, registers stay default.
// R21: Straps latched once per reset release, held until reset or write.
`timescale 1ns/1ps
module rsc_strap_loader
  import rsc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic master_reset_in,
  input wire logic [GPIO_N-1:0] gpio_in,
  input wire logic info_programmed,
  input wire logic [GPIO_N-1:0] info_addr_mask,
  input wire logic [GPIO_N-1:0] info_eep_mask,
  input wire logic [GPIO_N-1:0] info_sel_mask,
  input wire logic cfg_present,
  input wire logic cfg_load_done,
  input wire logic cfg_checksum_ok,
  input wire logic [CLK_OUT_N-1:0] cfg_clk_out_en,
  input wire logic [GPIO_N-1:0] cfg_gpio_input,
  input wire logic step_done,
  input wire logic sp_wr_proto,
  input wire logic sp_wr_addr_bit,
  input wire logic sp_wr_eep_dis,
  input wire logic sp_wr_cfg_sel,
  input wire logic [SEL_W-1:0] sp_wr_data,
  output logic aux_proto_i2c_r,
  output logic slave_addr_bit_two_r,
  output logic eeprom_search_dis_r,
  output logic [SEL_W-1:0] cfg_select_r,
  output logic cfg_load_req_r,
  output logic [STEP_N-1:0] step_req_r,
  output logic seq_busy_r,
  output logic hold_pin_fault_r,
  output logic [CLK_OUT_N-1:0] clk_out_en_r,
  output logic [GPIO_N-1:0] gpio_input_mode_r
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic mr_m_r;
  logic mr_s_r;
  logic mr_q_r;
  logic [GPIO_N-1:0] gpio_m_r;
  logic [GPIO_N-1:0] gpio_s_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mr_m_r <= 1'b0;
      mr_s_r <= 1'b0;
      mr_q_r <= 1'b0;
      // R9: idle pins read high
      gpio_m_r <= GPIO_INPUT_RST;
      gpio_s_r <= GPIO_INPUT_RST;
    end else begin
      mr_m_r <= master_reset_in;
      mr_s_r <= mr_m_r;
      mr_q_r <= mr_s_r;
      gpio_m_r <= gpio_in;
      gpio_s_r <= gpio_m_r;
    end
  end

  // ****************************************
  // Capture decode
  // ****************************************
  logic cap;
  logic in_reset;
  logic [GPIO_N-1:0] addr_mask;
  logic [GPIO_N-1:0] eep_mask;
  logic [GPIO_N-1:0] sel_mask;
  logic [SEL_W-1:0] sel_word;
  logic addr_pin;
  logic eep_dis;
  logic a2_nxt;

  // R1: capture on reset release
  assign cap = mr_s_r & ~mr_q_r;
  assign in_reset = ~mr_s_r;
  // R18: unprogrammed parts keep default roles
  assign addr_mask = info_programmed ? info_addr_mask : NO_ROLE_MASK;
  assign eep_mask = info_programmed ? info_eep_mask : NO_ROLE_MASK;
  assign sel_mask = info_programmed ? info_sel_mask : NO_ROLE_MASK;
  // R4: address bit only in I2C mode
  assign a2_nxt = gpio_s_r[PROTO_PIN] & addr_pin;

  // R11: alternative select pins
  rsc_role_decode u_decode (
    .pins(gpio_s_r),
    .addr_mask(addr_mask),
    .eep_mask(eep_mask),
    .sel_mask(sel_mask),
    .sel_word(sel_word),
    .addr_bit(addr_pin),
    .eep_dis(eep_dis)
  );

  // ****************************************
  // Strap-derived settings
  // ****************************************
  // R21: latched on capture, replaced only by writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_proto_i2c_r <= 1'b0;
      slave_addr_bit_two_r <= 1'b0;
      eeprom_search_dis_r <= 1'b0;
      cfg_select_r <= SEL_RST;
    end else if (cap) begin
      // R2: protocol from pin 9
      aux_proto_i2c_r <= gpio_s_r[PROTO_PIN];
      slave_addr_bit_two_r <= a2_nxt;
      // R6: disable EEPROM search
      eeprom_search_dis_r <= eep_dis;
      // R13: full-width select word
      cfg_select_r <= sel_word;
    end else if (!in_reset) begin
      // R15: serial overwrite
      if (sp_wr_proto) begin
        aux_proto_i2c_r <= sp_wr_data[0];
      end
      if (sp_wr_addr_bit) begin
        slave_addr_bit_two_r <= sp_wr_data[0];
      end
      if (sp_wr_eep_dis) begin
        eeprom_search_dis_r <= sp_wr_data[0];
      end
      if (sp_wr_cfg_sel) begin
        cfg_select_r <= sp_wr_data;
      end
    end
  end

  // Flags a board that lets pin 8 fall during reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_pin_fault_r <= 1'b0;
    end else if (cap) begin
      hold_pin_fault_r <= 1'b0;
    end else if (in_reset && !gpio_s_r[HOLD_PIN]) begin
      hold_pin_fault_r <= 1'b1;
    end
  end

  // ****************************************
  // Start-up sequence
  // ****************************************
  rsc_seq_type st_r;
  rsc_seq_type st_nxt;
  logic load_ok;
  logic load_end;

  assign load_end = (st_r == RSC_ST_LOAD) && (!cfg_present || cfg_load_done);
  // R20: apply only a good checksum
  assign load_ok = (st_r == RSC_ST_LOAD) && cfg_present && cfg_load_done && cfg_checksum_ok;

  // R17: fixed step order
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      RSC_ST_IDLE: begin
        if (cap) st_nxt = RSC_ST_LOAD;
      end
      RSC_ST_LOAD: begin
        if (load_end) st_nxt = RSC_ST_REG;
      end
      RSC_ST_REG: begin
        if (step_done) st_nxt = RSC_ST_CLK;
      end
      RSC_ST_CLK: begin
        if (step_done) st_nxt = RSC_ST_CAL;
      end
      RSC_ST_CAL: begin
        if (step_done) st_nxt = RSC_ST_LOCK;
      end
      RSC_ST_LOCK: begin
        if (step_done) st_nxt = RSC_ST_RUN;
      end
      RSC_ST_RUN: begin
        st_nxt = RSC_ST_RUN;
      end
      default: begin
        st_nxt = RSC_ST_IDLE;
      end
    endcase
    if (in_reset) st_nxt = RSC_ST_IDLE;
  end

  logic [STEP_N-1:0] step_nxt;
  assign step_nxt = (st_nxt == RSC_ST_REG) ? STEP_REG :
                    (st_nxt == RSC_ST_CLK) ? STEP_CLK :
                    (st_nxt == RSC_ST_CAL) ? STEP_CAL :
                    (st_nxt == RSC_ST_LOCK) ? STEP_LOCK : STEP_NONE;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= RSC_ST_IDLE;
      step_req_r <= STEP_NONE;
      seq_busy_r <= 1'b0;
      cfg_load_req_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      step_req_r <= step_nxt;
      seq_busy_r <= (st_nxt != RSC_ST_IDLE) && (st_nxt != RSC_ST_RUN);
      // R14: request only when a configuration exists
      cfg_load_req_r <= (st_nxt == RSC_ST_LOAD) && cfg_present && !load_end;
    end
  end

  // ****************************************
  // Register defaults and loaded values
  // ****************************************
  // R16: neutral defaults held during reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_out_en_r <= CLK_OUT_RST;
      gpio_input_mode_r <= GPIO_INPUT_RST;
    end else if (in_reset) begin
      clk_out_en_r <= CLK_OUT_RST;
      gpio_input_mode_r <= GPIO_INPUT_RST;
    end else if (load_ok) begin
      clk_out_en_r <= cfg_clk_out_en;
      gpio_input_mode_r <= cfg_gpio_input;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_proto_cap;
    @(posedge core_clk) disable iff (!rst_n)
    cap |=> aux_proto_i2c_r == $past(gpio_s_r[PROTO_PIN]);
  endproperty
  a_proto_cap: assert property (p_proto_cap) else $error("protocol not taken from pin 9"); // R2

  property p_addr_spi;
    @(posedge core_clk) disable iff (!rst_n)
    (cap && !gpio_s_r[PROTO_PIN]) |=> !slave_addr_bit_two_r;
  endproperty
  a_addr_spi: assert property (p_addr_spi) else $error("address bit set in SPI mode"); // R4

  property p_addr_none;
    @(posedge core_clk) disable iff (!rst_n)
    (cap && addr_mask == NO_ROLE_MASK) |=> !slave_addr_bit_two_r;
  endproperty
  a_addr_none: assert property (p_addr_none) else $error("address bit set without role"); // R4

  property p_eep_or;
    @(posedge core_clk) disable iff (!rst_n)
    cap |=> eeprom_search_dis_r == $past(|(gpio_s_r & eep_mask));
  endproperty
  a_eep_or: assert property (p_eep_or) else $error("EEPROM disable not OR of pins"); // R7

  property p_sel_default;
    @(posedge core_clk) disable iff (!rst_n)
    (cap && sel_mask == NO_ROLE_MASK) |=>
      cfg_select_r == ($past(gpio_s_r) & DEF_SEL_MASK);
  endproperty
  a_sel_default: assert property (p_sel_default) else $error("default select wrong"); // R8

  property p_sel_hold;
    @(posedge core_clk) disable iff (!rst_n)
    (!cap && !sp_wr_cfg_sel) |=> $stable(cfg_select_r);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select changed without cause"); // R21

  property p_sp_write;
    @(posedge core_clk) disable iff (!rst_n)
    (!cap && !in_reset && sp_wr_cfg_sel) |=> cfg_select_r == $past(sp_wr_data);
  endproperty
  a_sp_write: assert property (p_sp_write) else $error("serial write not applied"); // R15

  property p_defaults;
    @(posedge core_clk) disable iff (!rst_n)
    in_reset |=> (clk_out_en_r == CLK_OUT_RST) && (gpio_input_mode_r == GPIO_INPUT_RST);
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not held in reset"); // R16

  property p_order;
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == RSC_ST_REG && $past(st_r) != RSC_ST_REG) |-> $past(st_r) == RSC_ST_LOAD;
  endproperty
  a_order: assert property (p_order) else $error("regulators before config load"); // R17

  property p_bad_sum;
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == RSC_ST_LOAD && cfg_load_done && !cfg_checksum_ok && !in_reset) |=>
      $stable(clk_out_en_r) && $stable(gpio_input_mode_r);
  endproperty
  a_bad_sum: assert property (p_bad_sum) else $error("bad checksum configuration applied"); // R20

  property p_no_cfg;
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == RSC_ST_LOAD && !cfg_present && !in_reset) |=>
      !cfg_load_req_r && st_r == RSC_ST_REG;
  endproperty
  a_no_cfg: assert property (p_no_cfg) else $error("load attempted without configuration"); // R14

  c_i2c_boot: cover property (@(posedge core_clk) disable iff (!rst_n)
    cap && gpio_s_r[PROTO_PIN]);
  c_bad_sum: cover property (@(posedge core_clk) disable iff (!rst_n)
    st_r == RSC_ST_LOAD && cfg_load_done && !cfg_checksum_ok);
  c_run: cover property (@(posedge core_clk) disable iff (!rst_n)
    st_r == RSC_ST_LOCK ##1 st_r == RSC_ST_RUN);

endmodule

//--- verif/rsc_board_model.sv
// Board straps on the pins and start-up step responder
`timescale 1ns/1ps
module rsc_board_model
  import rsc_pkg::*;
(
  input wire logic core_clk,
  input wire logic mr_req,
  input wire logic bad_hold,
  input wire logic [GPIO_N-1:0] strap,
  input wire logic [3:0] ack_dly,
  input wire logic sum_good,
  input wire logic cfg_load_req_r,
  input wire logic [STEP_N-1:0] step_req_r,
  output logic master_reset_in,
  output logic [GPIO_N-1:0] gpio_in,
  output logic cfg_load_done,
  output logic cfg_checksum_ok,
  output logic step_done
);
  logic busy_r = 1'b0;
  logic [3:0] cnt_r = 4'h0;
  logic [1:0] gap_r = 2'h0;

  // ****************************************
  // Strap pins
  // ****************************************
  // board has no JTAG port
  always @(posedge core_clk) begin
    master_reset_in <= !mr_req;
    if (mr_req && !bad_hold) gpio_in <= strap | 10'h100;
    else if (mr_req) gpio_in <= strap & 10'h2ff;
    else gpio_in <= strap;
  end

  // ****************************************
  // Step responder
  // ****************************************
  assign cfg_checksum_ok = sum_good;

  always @(posedge core_clk) begin
    cfg_load_done <= 1'b0;
    step_done <= 1'b0;
    if (busy_r) begin
      if (cnt_r == 4'h0) begin
        busy_r <= 1'b0;
        gap_r <= 2'h2;
        cfg_load_done <= cfg_load_req_r;
        step_done <= !cfg_load_req_r;
      end else begin
        cnt_r <= cnt_r - 4'h1;
      end
    end else if (gap_r != 2'h0) begin
      gap_r <= gap_r - 2'h1;
    end else if (cfg_load_req_r || step_req_r != STEP_NONE) begin
      busy_r <= 1'b1;
      cnt_r <= ack_dly;
    end
  end
endmodule

//--- verif/reset_strap_config_select_test.sv
// Self-checking bench for the reset strap loader
`timescale 1ns/1ps
module reset_strap_config_select_test
  import rsc_pkg::*;
;
  logic core_clk;
  logic rst_n = 1'b0;
  logic mr_req = 1'b1;
  logic bad = 1'b0;
  logic [9:0] pins = 10'h3ff;
  logic prog = 1'b0;
  logic [9:0] am = 10'h000;
  logic [9:0] em = 10'h000;
  logic [9:0] sm = 10'h000;
  logic pres = 1'b0;
  logic good = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [3:0] wr_vec = 4'h0;
  logic [9:0] wr_data = 10'h000;
  logic master_reset_in, cfg_load_done, cfg_checksum_ok, step_done;
  logic [9:0] gpio_in, cfg_select_r, gpio_input_mode_r;
  logic aux_proto_i2c_r, slave_addr_bit_two_r, eeprom_search_dis_r;
  logic cfg_load_req_r, seq_busy_r, hold_pin_fault_r;
  logic [3:0] step_req_r;
  logic [7:0] clk_out_en_r;
  int n_fail = 0;
  int total_checks = 0;
  logic [3:0] seen [$];
  logic [3:0] last_req = 4'h0;
  logic req_seen = 1'b0;

  // ****************************************
  // Design and board
  // ****************************************
  rsc_strap_loader u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .master_reset_in(master_reset_in), .gpio_in(gpio_in), .info_programmed(prog),
    .info_addr_mask(am), .info_eep_mask(em), .info_sel_mask(sm), .cfg_present(pres),
    .cfg_load_done(cfg_load_done), .cfg_checksum_ok(cfg_checksum_ok),
    .cfg_clk_out_en(8'h5a), .cfg_gpio_input(10'h2c3), .step_done(step_done),
    .sp_wr_proto(wr_vec[0]), .sp_wr_addr_bit(wr_vec[1]), .sp_wr_eep_dis(wr_vec[2]),
    .sp_wr_cfg_sel(wr_vec[3]), .sp_wr_data(wr_data), .aux_proto_i2c_r(aux_proto_i2c_r),
    .slave_addr_bit_two_r(slave_addr_bit_two_r), .eeprom_search_dis_r(eeprom_search_dis_r),
    .cfg_select_r(cfg_select_r), .cfg_load_req_r(cfg_load_req_r), .step_req_r(step_req_r),
    .seq_busy_r(seq_busy_r), .hold_pin_fault_r(hold_pin_fault_r),
    .clk_out_en_r(clk_out_en_r), .gpio_input_mode_r(gpio_input_mode_r));

  rsc_board_model u_board (.core_clk(core_clk), .mr_req(mr_req), .bad_hold(bad),
    .strap(pins), .ack_dly(dly), .sum_good(good), .cfg_load_req_r(cfg_load_req_r),
    .step_req_r(step_req_r), .master_reset_in(master_reset_in), .gpio_in(gpio_in),
    .cfg_load_done(cfg_load_done), .cfg_checksum_ok(cfg_checksum_ok),
    .step_done(step_done));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Log of step and load requests
  always @(posedge core_clk) begin
    if (step_req_r !== STEP_NONE && step_req_r !== last_req) seen.push_back(step_req_r);
    last_req <= step_req_r;
    if (mr_req) req_seen <= 1'b0;
    else if (cfg_load_req_r === 1'b1) req_seen <= 1'b1;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task chk(input logic [SEL_W-1:0] got, input logic [SEL_W-1:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task wait_busy(input logic lvl, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge core_clk);
      if (seq_busy_r === lvl) break;
    end
    @(negedge core_clk);
    chk({9'h0, seq_busy_r}, {9'h0, lvl}, "busy");
  endtask

  task boot(input logic [9:0] p, input logic pg, input logic [9:0] a, e, s,
            input logic pr, gd, bh, input logic [3:0] d);
    @(posedge core_clk);
    mr_req <= 1'b1;
    pins <= p;
    prog <= pg;
    am <= a;
    em <= e;
    sm <= s;
    pres <= pr;
    good <= gd;
    bad <= bh;
    dly <= d;
    seen.delete();
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    chk({9'h0, hold_pin_fault_r}, {9'h0, bh}, "hold fault");
    chk({2'h0, clk_out_en_r}, 10'h000, "clk out in reset");
    chk(gpio_input_mode_r, GPIO_INPUT_RST, "gpio mode in reset");
    @(posedge core_clk);
    mr_req <= 1'b0;
    wait_busy(1'b1, 20);
  endtask

  task chk_straps(input logic p, a, e, input logic [9:0] s);
    chk({9'h0, aux_proto_i2c_r}, {9'h0, p}, "proto");
    chk({9'h0, slave_addr_bit_two_r}, {9'h0, a}, "addr bit");
    chk({9'h0, eeprom_search_dis_r}, {9'h0, e}, "eeprom dis");
    chk(cfg_select_r, s, "select");
  endtask

  task chk_run(input logic [7:0] ce, input logic [9:0] ge);
    wait_busy(1'b0, 200);
    chk(10'(seen.size()), 10'h004, "step count");
    for (int i = 0; i < 4; i++) chk({6'h0, seen[i]}, {6'h0, 4'h1 << i}, "step");
    chk({9'h0, req_seen}, {9'h0, pres}, "load request");
    chk({2'h0, clk_out_en_r}, {2'h0, ce}, "clk out");
    chk(gpio_input_mode_r, ge, "gpio mode");
  endtask

  task sp_burst(input logic [3:0] bits, input logic [9:0] sel);
    @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      wr_vec <= 4'h1 << i;
      wr_data <= (i == 3) ? sel : {9'h0, bits[i]};
      @(posedge core_clk);
    end
    wr_vec <= 4'h0;
    @(negedge core_clk);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    boot(10'h3ff, 1'b0, 10'h0a0, 10'h006, 10'h164, 1'b1, 1'b1, 1'b0, 4'h3);
    chk_straps(1'b1, 1'b0, 1'b0, 10'h00f);
    chk_run(8'h5a, 10'h2c3);
    $display("test unprogrammed done");
    boot(10'h305, 1'b1, 10'h000, 10'h000, 10'h000, 1'b0, 1'b1, 1'b0, 4'h0);
    chk_straps(1'b1, 1'b0, 1'b0, 10'h005);
    chk_run(8'h00, 10'h3ff);
    $display("test default pins done");
    boot(10'h384, 1'b1, 10'h0a0, 10'h006, 10'h164, 1'b1, 1'b0, 1'b0, 4'h0);
    chk_straps(1'b1, 1'b1, 1'b1, 10'h009);
    chk_run(8'h00, 10'h3ff);
    $display("test masks done");
    boot(10'h182, 1'b1, 10'h0a0, 10'h000, 10'h003, 1'b0, 1'b1, 1'b1, 4'h1);
    chk_straps(1'b0, 1'b0, 1'b0, 10'h002);
    chk_run(8'h00, 10'h3ff);
    $display("test spi done");
    boot(10'h32d, 1'b1, 10'h000, 10'h000, 10'h03f, 1'b1, 1'b1, 1'b0, 4'h2);
    chk_straps(1'b1, 1'b0, 1'b0, 10'h02d);
    chk_run(8'h5a, 10'h2c3);
    sp_burst(4'b0110, 10'h2aa);
    chk_straps(1'b0, 1'b1, 1'b1, 10'h2aa);
    @(posedge core_clk);
    mr_req <= 1'b1;
    repeat (4) @(posedge core_clk);
    sp_burst(4'b0001, 10'h155);
    chk_straps(1'b0, 1'b1, 1'b1, 10'h2aa);
    $display("test serial writes done");
    end_of_test();
  end

  initial begin
    #500000;
    n_fail++;
    end_of_test();
  end
endmodule
